// [pkg/btpwh_pkg.sv]
`default_nettype none
package btpwh_pkg;
  // Clock rates and the low-power tick divider
  localparam int unsigned CLK_FREQ_HZ = 250_000_000;
  localparam int unsigned LPO_FREQ_HZ = 32_768;
  localparam int unsigned LPO_DIV_DFLT = CLK_FREQ_HZ / LPO_FREQ_HZ;
  localparam int LPO_CNT_W = 16;
  localparam int INTERVAL_W = 16;

  // Reset values
  localparam logic REF_CLK_REQ_RST = 1'b0;
  localparam logic POL_ACTIVE_HIGH = 1'b1;

  // Connection low-power modes
  typedef enum logic [1:0] {
    LPM_NONE,
    LPM_SNIFF,
    LPM_HOLD,
    LPM_PARK
  } btpwh_lpmode_t;

  // Power states of the section
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_LOWPWR,
    ST_SHUTDOWN
  } btpwh_state_t;

  // Software configuration
  typedef struct packed {
    logic devWakePol;
    logic hostWakePol;
    btpwh_lpmode_t lpMode;
    logic [INTERVAL_W-1:0] wakeInterval;
  } btpwh_cfg_t;

  // Transceiver power-down controls, high means powered down
  typedef struct packed {
    logic tx;
    logic rx;
    logic pll;
    logic pa;
  } btpwh_rfpd_t;

  localparam btpwh_rfpd_t RFPD_ALL_OFF = '{tx: 1'b1, rx: 1'b1, pll: 1'b1, pa: 1'b1};
endpackage
`default_nettype wire

// [hw/btpwh_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module btpwh_sync2 (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_ff;
  logic nxt_stage1;
  logic stage2_ff;
  logic nxt_stage2;

  // Stage one feeds only stage two
  always_comb begin
    nxt_stage1 = asyncIn;
    nxt_stage2 = stage1_ff;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_ff <= 1'b0;
      stage2_ff <= 1'b0;
    end else begin
      stage1_ff <= nxt_stage1;
      stage2_ff <= nxt_stage2;
    end
  end

  assign syncOut = stage2_ff;
endmodule
`default_nettype wire

// [hw/btpwh_top.sv]
// Function
// R1: Sleep entry can be triggered both by a software request and by the baseband core.
// R2: Separate power-down outputs go to the transceiver for transmit, receive, PLL and PA.
// R3: An asserted device_wake_request wakes the device and blocks any sleep entry.
// R4: With device_wake_request deasserted, sleep is entered only once sleep criteria hold.
// R5: The active level of both wake signals is chosen by software configuration.
// R6: When host_wake_request is asserted, the host wakes or stays awake to serve the device.
// R7: While host_wake_request is deasserted, the host may sleep on its own criteria.
// R8: ref_clock_request is raised when either the Bluetooth or the WLAN section needs clock.
// R9: ref_clock_request is active high and is low during power-up and reset.
// R10: The radio paths are powered only while a packet is being sent or received.
// R11: Sniff, hold and park run on low-power ticks and wake after a set interval.
// R12: In shutdown every output is released and most inputs are ignored; the code releases only host wake and ref clock request.
// R13: Leaving shutdown behaves as a fresh power-up with no kept state.
// R14: The wake signals act as a low-power out-of-band companion to the UART transport.
// R15: device_wake_request passes a two-stage synchroniser before any decision uses it.
`timescale 1ns/1ps
`default_nettype none
module btpwh_top #(
  parameter int unsigned LPO_DIV_CYCLES = btpwh_pkg::LPO_DIV_DFLT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic devWakePin,
  input wire btpwh_pkg::btpwh_cfg_t cfg,
  input wire logic swSleepReq,
  input wire logic bbSleepReq,
  input wire logic sleepCriteriaMet,
  input wire logic bbHostAttn,
  input wire logic bbTxActive,
  input wire logic bbRxActive,
  input wire logic wlanClkNeed,
  input wire logic shutdownReq,
  output logic hostWakeOut,
  output logic hostWakeOe,
  output logic refClkReqOut,
  output logic refClkReqOe,
  output btpwh_pkg::btpwh_rfpd_t rfPowerDown,
  output btpwh_pkg::btpwh_state_t pwrState,
  output logic lpoClkSel,
  output logic intervalWake
);
  import btpwh_pkg::*;

  localparam logic [LPO_CNT_W-1:0] LPO_DIV_LAST = LPO_CNT_W'(LPO_DIV_CYCLES - 1);

  logic devWakeSync;
  logic devWakeAsserted;
  logic inputsOn;
  logic lpoTick;
  logic sleepTrigger;

  btpwh_state_t state_ff;
  btpwh_state_t nxt_state;
  logic [LPO_CNT_W-1:0] lpoCnt_ff;
  logic [LPO_CNT_W-1:0] nxt_lpoCnt;
  logic [INTERVAL_W-1:0] ivlCnt_ff;
  logic [INTERVAL_W-1:0] nxt_ivlCnt;
  logic intervalWake_ff;
  logic nxt_intervalWake;
  btpwh_rfpd_t rfpd_ff;
  btpwh_rfpd_t nxt_rfpd;
  logic hostWake_ff;
  logic nxt_hostWake;
  logic hostWakeOe_ff;
  logic nxt_hostWakeOe;
  logic refClkReq_ff;
  logic nxt_refClkReq;
  logic refClkOe_ff;
  logic nxt_refClkOe;

  // Wake pin comes from the host clock domain
  btpwh_sync2 u_devWakeSync ( // [R15]
    .ref_clk(ref_clk),
    .rst(rst),
    .asyncIn(devWakePin),
    .syncOut(devWakeSync)
  );

  // Input gating and polarity; shutdown ignores host inputs
  always_comb begin
    inputsOn = (state_ff != ST_SHUTDOWN); // [R12]
    devWakeAsserted = inputsOn && (devWakeSync == cfg.devWakePol); // [R5] [R14]
    sleepTrigger = inputsOn && (swSleepReq || bbSleepReq); // [R1]
  end

  // Low-power tick divider, a clock enable rather than a second clock
  always_comb begin
    lpoTick = (lpoCnt_ff == LPO_DIV_LAST);
    if (state_ff == ST_SHUTDOWN || lpoTick) begin
      nxt_lpoCnt = '0;
    end else begin
      nxt_lpoCnt = lpoCnt_ff + 1'b1;
    end
  end

  // Power state machine; shutdown clears everything so exit is a fresh start
  always_comb begin
    nxt_state = state_ff;
    nxt_ivlCnt = ivlCnt_ff;
    nxt_intervalWake = 1'b0;
    unique case (state_ff)
      ST_ACTIVE: begin
        nxt_ivlCnt = '0;
        if (shutdownReq) begin
          nxt_state = ST_SHUTDOWN;
        end else if (!devWakeAsserted && sleepCriteriaMet && sleepTrigger) begin // [R3] [R4]
          nxt_state = (cfg.lpMode == LPM_NONE) ? ST_SLEEP : ST_LOWPWR;
        end
      end
      ST_SLEEP: begin
        if (shutdownReq) begin
          nxt_state = ST_SHUTDOWN;
        end else if (devWakeAsserted) begin // [R3]
          nxt_state = ST_ACTIVE;
        end
      end
      ST_LOWPWR: begin
        if (shutdownReq) begin
          nxt_state = ST_SHUTDOWN;
        end else if (devWakeAsserted) begin // [R3]
          nxt_state = ST_ACTIVE;
        end else if (lpoTick) begin
          // Interval counted in low-power ticks
          if (ivlCnt_ff + 1'b1 >= cfg.wakeInterval) begin // [R11]
            nxt_state = ST_ACTIVE;
            nxt_intervalWake = 1'b1;
          end else begin
            nxt_ivlCnt = ivlCnt_ff + 1'b1;
          end
        end
      end
      ST_SHUTDOWN: begin
        nxt_ivlCnt = '0; // [R13]
        if (!shutdownReq) begin
          nxt_state = ST_ACTIVE;
        end
      end
    endcase
  end

  // Outputs toward radio, host and clock source
  always_comb begin
    nxt_rfpd = RFPD_ALL_OFF;
    nxt_hostWake = !cfg.hostWakePol;
    nxt_hostWakeOe = 1'b1;
    nxt_refClkReq = wlanClkNeed || (nxt_state == ST_ACTIVE); // [R8]
    nxt_refClkOe = 1'b1;
    if (nxt_state == ST_ACTIVE) begin
      // Radio on only inside packets
      nxt_rfpd.tx = !bbTxActive; // [R2] [R10]
      nxt_rfpd.pa = !bbTxActive; // [R2] [R10]
      nxt_rfpd.rx = !bbRxActive; // [R2] [R10]
      nxt_rfpd.pll = !(bbTxActive || bbRxActive); // [R2] [R10]
    end
    if (nxt_state != ST_SHUTDOWN && bbHostAttn) begin
      nxt_hostWake = cfg.hostWakePol; // [R5] [R6] [R7]
    end
    if (nxt_state == ST_SHUTDOWN) begin
      // Released pins draw no current from the system
      nxt_hostWakeOe = 1'b0; // [R12]
      nxt_refClkOe = 1'b0; // [R12]
      nxt_refClkReq = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_ACTIVE;
      lpoCnt_ff <= '0;
      ivlCnt_ff <= '0;
      intervalWake_ff <= 1'b0;
      rfpd_ff <= RFPD_ALL_OFF;
      hostWake_ff <= !POL_ACTIVE_HIGH;
      hostWakeOe_ff <= 1'b1;
      refClkReq_ff <= REF_CLK_REQ_RST; // [R9]
      refClkOe_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      lpoCnt_ff <= nxt_lpoCnt;
      ivlCnt_ff <= nxt_ivlCnt;
      intervalWake_ff <= nxt_intervalWake;
      rfpd_ff <= nxt_rfpd;
      hostWake_ff <= nxt_hostWake;
      hostWakeOe_ff <= nxt_hostWakeOe;
      refClkReq_ff <= nxt_refClkReq;
      refClkOe_ff <= nxt_refClkOe;
    end
  end

  assign hostWakeOut = hostWake_ff;
  assign hostWakeOe = hostWakeOe_ff;
  assign refClkReqOut = refClkReq_ff;
  assign refClkReqOe = refClkOe_ff;
  assign rfPowerDown = rfpd_ff;
  assign pwrState = state_ff;
  assign lpoClkSel = (state_ff == ST_LOWPWR); // [R11]
  assign intervalWake = intervalWake_ff;

  // Checks beside the logic
  a_wake_blocks_sleep: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    (state_ff == ST_ACTIVE && devWakeAsserted && !shutdownReq) |=> state_ff == ST_ACTIVE)
    else $error("sleep entered while wake asserted");
  a_sleep_needs_criteria: assert property (@(posedge ref_clk) disable iff (rst) // [R4]
    (state_ff inside {ST_SLEEP, ST_LOWPWR} && $past(state_ff) == ST_ACTIVE)
    |-> $past(sleepCriteriaMet) && $past(sleepTrigger) && !$past(devWakeAsserted))
    else $error("sleep without criteria");
  a_sleep_wakes_up: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    (state_ff inside {ST_SLEEP, ST_LOWPWR} && devWakeAsserted && !shutdownReq)
    |=> state_ff == ST_ACTIVE)
    else $error("wake request ignored");
  a_refclk_wlan: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (wlanClkNeed && nxt_state != ST_SHUTDOWN) |=> refClkReqOut)
    else $error("clock request missing for wlan");
  a_tx_path_on: assert property (@(posedge ref_clk) disable iff (rst) // [R10]
    (nxt_state == ST_ACTIVE && bbTxActive) |=> !rfPowerDown.tx && !rfPowerDown.pa && !rfPowerDown.pll)
    else $error("tx path not powered");
  a_rf_off_idle: assert property (@(posedge ref_clk) disable iff (rst) // [R2]
    (!bbTxActive && !bbRxActive) |=> rfPowerDown == RFPD_ALL_OFF)
    else $error("radio powered while idle");
  a_host_wake_pol: assert property (@(posedge ref_clk) disable iff (rst) // [R5]
    (bbHostAttn && nxt_state != ST_SHUTDOWN) |=> hostWakeOut == $past(cfg.hostWakePol))
    else $error("host wake level wrong");
  a_shutdown_tristate: assert property (@(posedge ref_clk) disable iff (rst) // [R12]
    (state_ff == ST_SHUTDOWN) |-> !hostWakeOe && !refClkReqOe && !refClkReqOut)
    else $error("outputs driven in shutdown");
  a_shutdown_fresh: assert property (@(posedge ref_clk) disable iff (rst) // [R13]
    (state_ff == ST_SHUTDOWN && !shutdownReq) |=> state_ff == ST_ACTIVE && ivlCnt_ff == '0)
    else $error("state kept across shutdown");
  a_lpo_tick_only: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    intervalWake |-> $past(lpoTick) && $past(state_ff) == ST_LOWPWR)
    else $error("interval wake off tick");

  c_enter_sleep: cover property (@(posedge ref_clk) disable iff (rst)
    state_ff == ST_ACTIVE ##1 state_ff == ST_SLEEP);
  c_interval_wake: cover property (@(posedge ref_clk) disable iff (rst) intervalWake);
  c_shutdown_exit: cover property (@(posedge ref_clk) disable iff (rst)
    state_ff == ST_SHUTDOWN ##1 state_ff == ST_ACTIVE);
  c_host_wake: cover property (@(posedge ref_clk) disable iff (rst)
    hostWakeOut == cfg.hostWakePol);
endmodule
`default_nettype wire

// [bench/btpwh_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module btpwh_host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wantWake,
  input wire logic devWakePol,
  input wire logic hostWakePol,
  input wire logic hostWakeOut,
  input wire logic hostWakeOe,
  output logic devWakePin,
  output logic hostAwake_ff
);
  logic nxt_hostAwake;
  // Out-of-band wake line, level per chosen polarity
  assign devWakePin = wantWake ? devWakePol : ~devWakePol;
  // Host stays up while asked, dozes otherwise; undriven line means no request
  always_comb begin
    nxt_hostAwake = hostWakeOe && (hostWakeOut == hostWakePol);
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hostAwake_ff <= 1'b0;
    end else begin
      hostAwake_ff <= nxt_hostAwake;
    end
  end
endmodule
`default_nettype wire

// [bench/btpwh_top_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module btpwh_top_tb;
  import btpwh_pkg::*;
  typedef struct packed {
    logic [6:0] in;
    btpwh_state_t st;
    logic clkReq;
    logic [3:0] rf;
    logic hw;
  } btpwh_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic wantWake = 1'b0;
  logic swS = 1'b0, bbS = 1'b0, crit = 1'b0, attn = 1'b0, tx = 1'b0, rx = 1'b0;
  logic wlan = 1'b0, shut = 1'b0;
  btpwh_cfg_t cfg = '{1'b1, 1'b1, LPM_NONE, 16'h0003};
  logic devPin, hwOut, hwOe, refOut, refOe, lpoSel, ivWake, hostAwake;
  btpwh_rfpd_t rfpd;
  btpwh_state_t st;
  int nErrors = 0;
  int nCompared = 0;
  int k;
  // Inputs are {sw, bb, criteria, attn, tx, rx, wlan}
  btpwh_row_t rows [8] = '{
    '{7'h00, ST_ACTIVE, 1'b1, 4'hF, 1'b0}, '{7'h04, ST_ACTIVE, 1'b1, 4'h4, 1'b0},
    '{7'h02, ST_ACTIVE, 1'b1, 4'h9, 1'b0}, '{7'h06, ST_ACTIVE, 1'b1, 4'h0, 1'b0},
    '{7'h08, ST_ACTIVE, 1'b1, 4'hF, 1'b1}, '{7'h40, ST_ACTIVE, 1'b1, 4'hF, 1'b0},
    '{7'h20, ST_ACTIVE, 1'b1, 4'hF, 1'b0}, '{7'h11, ST_ACTIVE, 1'b1, 4'hF, 1'b0}};

  always #2 ref_clk = ~ref_clk;

  btpwh_top #(.LPO_DIV_CYCLES(4)) uut (.ref_clk(ref_clk), .rst(rst), .devWakePin(devPin),
    .cfg(cfg), .swSleepReq(swS), .bbSleepReq(bbS), .sleepCriteriaMet(crit), .bbHostAttn(attn),
    .bbTxActive(tx), .bbRxActive(rx), .wlanClkNeed(wlan), .shutdownReq(shut),
    .hostWakeOut(hwOut), .hostWakeOe(hwOe), .refClkReqOut(refOut), .refClkReqOe(refOe),
    .rfPowerDown(rfpd), .pwrState(st), .lpoClkSel(lpoSel), .intervalWake(ivWake));

  btpwh_host_model hostModel (.ref_clk(ref_clk), .rst(rst), .wantWake(wantWake),
    .devWakePol(cfg.devWakePol), .hostWakePol(cfg.hostWakePol), .hostWakeOut(hwOut),
    .hostWakeOe(hwOe), .devWakePin(devPin), .hostAwake_ff(hostAwake));

  task automatic chkBit(input string nm, input logic e, input logic g);
    nCompared++;
    if (g !== e) begin
      nErrors++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chkSt(input btpwh_state_t e);
    nCompared++;
    if (st !== e) begin
      nErrors++;
      $display("BAD pwrState exp %0d got %0d", e, st);
    end
  endtask
  task automatic chkRf(input logic [3:0] e);
    nCompared++;
    if (rfpd !== e) begin
      nErrors++;
      $display("BAD rfPowerDown exp %h got %h", e, rfpd);
    end
  endtask
  // Advance n edges, then land on a falling edge where outputs are settled
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  task automatic giveVerdict();
    $display("compared %0d, mismatches %0d", nCompared, nErrors);
    if (nErrors == 0 && nCompared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Bound sized well above the roughly 120 cycles the tests need
  initial begin
    #40000;
    nErrors++;
    giveVerdict();
  end

  initial begin
    repeat (20) @(negedge ref_clk);
    chkBit("refClkReqOut", 1'b0, refOut);
    chkRf(4'hF);
    rst = 1'b0;
    tick(1);
    chkBit("refClkReqOut", 1'b1, refOut);
    $display("reset test done");
    foreach (rows[i]) begin
      {swS, bbS, crit, attn, tx, rx, wlan} = rows[i].in;
      tick(1);
      chkSt(rows[i].st);
      chkBit("refClkReqOut", rows[i].clkReq, refOut);
      chkRf(rows[i].rf);
      chkBit("hostWakeOut", rows[i].hw, hwOut);
    end
    {swS, bbS, crit, attn, tx, rx, wlan} = 7'h00;
    tick(1);
    $display("table test done");
    // Sleep and wake for both wake polarities; trigger held through the wake
    for (int p = 0; p < 2; p++) begin
      cfg.devWakePol = p[0];
      tick(3);
      swS = 1'b1;
      crit = 1'b1;
      tick(1);
      chkSt(ST_SLEEP);
      chkBit("refClkReqOut", 1'b0, refOut);
      wlan = 1'b1;
      tick(1);
      chkBit("refClkReqOut", 1'b1, refOut);
      wlan = 1'b0;
      wantWake = 1'b1;
      tick(2);
      chkSt(ST_SLEEP);
      tick(1);
      chkSt(ST_ACTIVE);
      tick(2);
      chkSt(ST_ACTIVE);
      wantWake = 1'b0;
      tick(3);
      chkSt(ST_SLEEP);
      {swS, crit, wantWake} = 3'b001;
      tick(3);
      chkSt(ST_ACTIVE);
      wantWake = 1'b0;
    end
    $display("wake test done");
    attn = 1'b1;
    cfg.hostWakePol = 1'b0;
    tick(1);
    chkBit("hostWakeOut", 1'b0, hwOut);
    tick(1);
    chkBit("hostAwake", 1'b1, hostAwake);
    attn = 1'b0;
    tick(2);
    chkBit("hostWakeOut", 1'b1, hwOut);
    chkBit("hostAwake", 1'b0, hostAwake);
    cfg.hostWakePol = 1'b1;
    tick(1);
    $display("host wake test done");
    // Three ticks of four clocks each before the interval wake
    for (int m = 1; m < 4; m++) begin
      cfg.lpMode = btpwh_lpmode_t'(m);
      {bbS, crit} = 2'b11;
      tick(1);
      chkSt(ST_LOWPWR);
      chkBit("lpoClkSel", 1'b1, lpoSel);
      {bbS, crit} = 2'b00;
      k = 1;
      while (ivWake !== 1'b1 && k < 40) begin
        tick(1);
        k++;
      end
      chkBit("intervalWake", 1'b1, ivWake);
      chkBit("wakeSpan", 1'b1, k >= 10 && k <= 13);
      chkSt(ST_ACTIVE);
      tick(1);
      chkBit("intervalWake", 1'b0, ivWake);
    end
    cfg.lpMode = LPM_NONE;
    $display("low power test done");
    {wantWake, attn, shut} = 3'b111;
    tick(1);
    chkSt(ST_SHUTDOWN);
    chkBit("hostWakeOe", 1'b0, hwOe);
    chkBit("refClkReqOe", 1'b0, refOe);
    chkBit("refClkReqOut", 1'b0, refOut);
    tick(4);
    chkSt(ST_SHUTDOWN);
    {wantWake, attn, shut} = 3'b000;
    tick(1);
    chkSt(ST_ACTIVE);
    chkBit("refClkReqOut", 1'b1, refOut);
    chkBit("hostWakeOe", 1'b1, hwOe);
    $display("shutdown test done");
    // Mid-run reset while WLAN asks for clock; the request must still read low
    wlan = 1'b1;
    tick(1);
    rst = 1'b1;
    tick(2);
    chkBit("refClkReqOut", 1'b0, refOut);
    chkRf(4'hF);
    chkSt(ST_ACTIVE);
    chkBit("intervalWake", 1'b0, ivWake);
    rst = 1'b0;
    wlan = 1'b0;
    tick(1);
    chkBit("refClkReqOut", 1'b1, refOut);
    $display("mid-run reset test done");
    giveVerdict();
  end
endmodule
`default_nettype wire
